//--- pkg/csr_map.vh
// Register indices, reset values and field positions of the core status/option block
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
// ==========================================================
// Register indices (byte address is four times the index)
`define CSR_IDX_TZ_B0      9'h001
`define CSR_IDX_TZ_B2      9'h101
`define CSR_IDX_STAT_B0    9'h003
`define CSR_IDX_STAT_B1    9'h083
`define CSR_IDX_STAT_B2    9'h103
`define CSR_IDX_STAT_B3    9'h183
`define CSR_IDX_OPT_B1     9'h081
`define CSR_IDX_OPT_B3     9'h181
`define CSR_IDX_IRQC_B0    9'h00B
`define CSR_IDX_IRQC_B1    9'h08B
`define CSR_IDX_IRQC_B2    9'h10B
`define CSR_IDX_IRQC_B3    9'h18B
`define CSR_IDX_EVT_STAT   9'h1F0
`define CSR_IDX_EVT_MASK   9'h1F1
// ==========================================================
// Reset values
`define CSR_RST_STAT       8'h18
`define CSR_RST_OPT        8'hFF
`define CSR_RST_IRQC       8'h00
`define CSR_RST_TZ         8'h00
`define CSR_RST_EVT        3'h0
// ==========================================================
// Status register fields
`define CSR_ST_IND_BANK    7
`define CSR_ST_BANK_HI     6
`define CSR_ST_BANK_LO     5
`define CSR_ST_WDX         4
`define CSR_ST_SLP         3
`define CSR_ST_ZERO        2
`define CSR_ST_NIB         1
`define CSR_ST_CARRY       0
// ==========================================================
// Option register fields
`define CSR_OP_PUD         7
`define CSR_OP_EDGE        6
`define CSR_OP_TZ_SRC      5
`define CSR_OP_TZ_EDGE     4
`define CSR_OP_ASSIGN      3
`define CSR_OP_RATE_HI     2
`define CSR_OP_RATE_LO     0
// ==========================================================
// Interrupt control register fields
`define CSR_IC_GLOBAL      7
`define CSR_IC_PERIPH      6
`define CSR_IC_TZ_EN       5
`define CSR_IC_EXT_EN      4
`define CSR_IC_CHG_EN      3
`define CSR_IC_TZ_FLAG     2
`define CSR_IC_EXT_FLAG    1
`define CSR_IC_CHG_FLAG    0
// ==========================================================
// Event status / mask fields
`define CSR_EV_TZ          0
`define CSR_EV_EXT         1
`define CSR_EV_CHG         2
`define CSR_EV_W           3
`endif

//--- rtl/csr_sync2.v
// Two-flop synchroniser for asynchronous pin inputs
module csr_sync2 #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  // ==========================================================
  // Synchroniser stages
  reg [W-1:0] meta_r;  // First stage, read only by second stage
  reg [W-1:0] sync_r;  // Second stage, safe to use

  // Two flops in series, no logic between
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

//--- rtl/csr_prescaler.v
// Shared prescaler, assignable to timer zero or the watchdog
module csr_prescaler #(
  parameter W = 8
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clr,
  input  wire       assign_wdt,
  input  wire [2:0] rate,
  input  wire       tmr_tick,
  input  wire       wdt_tick,
  output wire       tmr_inc,
  output wire       wdt_inc
);

  // ==========================================================
  // Divider state
  reg  [W-1:0] cnt_r;       // Prescaler count
  reg          tmr_inc_r;   // Timer increment pulse
  reg          wdt_inc_r;   // Watchdog increment pulse
  wire         src;         // Tick of the owner of the prescaler
  wire [3:0]   shift;       // Log2 of the division ratio
  wire [W-1:0] mask;        // Low bits that must wrap
  wire [W-1:0] cnt_nxt;     // Count after this tick
  wire         hit;         // Division ratio reached

  // Only one owner at a time
  assign src     = assign_wdt ? wdt_tick : tmr_tick;
  // Timer 1:2..1:256, watchdog 1:1..1:128
  assign shift   = assign_wdt ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
  assign mask    = ({{(W-1){1'b0}}, 1'b1} << shift) - {{(W-1){1'b0}}, 1'b1};
  assign cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
  assign hit     = src & ((cnt_nxt & mask) == {W{1'b0}});

  // Count, and route the divided tick to its owner
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= {W{1'b0}};
      tmr_inc_r <= 1'b0;
      wdt_inc_r <= 1'b0;
    end else begin
      if (clr) begin
        cnt_r <= {W{1'b0}};
      end else if (src) begin
        cnt_r <= cnt_nxt;
      end
      // Unowned side runs undivided
      tmr_inc_r <= assign_wdt ? tmr_tick : hit;
      wdt_inc_r <= assign_wdt ? hit : wdt_tick;
    end
  end

  assign tmr_inc = tmr_inc_r;
  assign wdt_inc = wdt_inc_r;

endmodule

//--- rtl/csr_core_regs.v
// Core status, option and interrupt control registers behind APB
`include "csr_map.vh"
module csr_core_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [10:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        instr_tick,
  input  wire        wdt_base_tick,
  input  wire        t0_pin,
  input  wire        ext_irq_pin,
  input  wire [3:0]  port_b_pins,
  input  wire        periph_irq_req,
  input  wire        alu_valid,
  input  wire        alu_sub,
  input  wire        alu_dest_status,
  input  wire [7:0]  alu_a,
  input  wire [7:0]  alu_b,
  input  wire        wdt_timeout_evt,
  input  wire        sleep_evt,
  input  wire        clrwdt_evt,
  output wire [7:0]  alu_result,
  output wire        indirect_bank_select,
  output wire        direct_bank_select_high,
  output wire        direct_bank_select_low,
  output wire        port_b_pullup_disable,
  output wire        wdt_inc,
  output wire        core_irq,
  output wire        apb_irq
);

  // ==========================================================
  // Registers and bus state
  reg  [7:0]  stat_r;      // Arithmetic status and bank select
  reg  [7:0]  opt_r;       // Timer/prescale options
  reg  [7:0]  irqc_r;      // Interrupt control register
  reg  [7:0]  tz_r;        // Timer zero count
  reg  [2:0]  evt_r;       // Sticky bus-side events
  reg  [2:0]  mask_r;      // Event mask
  reg  [7:0]  res_r;       // Latched adder result
  reg  [31:0] prdata_r;    // Read data
  reg         pready_r;    // Access-phase completion
  reg         pslverr_r;   // Unmapped address answer
  reg         core_irq_r;  // Interrupt request to core
  reg         apb_irq_r;   // Interrupt to system
  reg  [5:0]  pin_prev_r;  // Previous synced pin levels
  // Next values, built by the combinational processes below
  reg  [7:0]  stat_nxt;
  reg  [7:0]  irqc_nxt;
  reg  [7:0]  tz_nxt;
  reg  [2:0]  evt_nxt;
  reg  [31:0] rd_nxt;
  reg         err_nxt;

  // ==========================================================
  // Bus decode
  wire [8:0] idx    = paddr[10:2];              // Register index
  wire       access = psel & penable & pready_r; // Completion edge
  wire       wr     = access & pwrite;
  wire       sel_stat = (idx == `CSR_IDX_STAT_B0) | (idx == `CSR_IDX_STAT_B1) |
                        (idx == `CSR_IDX_STAT_B2) | (idx == `CSR_IDX_STAT_B3);
  wire       sel_opt  = (idx == `CSR_IDX_OPT_B1) | (idx == `CSR_IDX_OPT_B3);
  wire       sel_irqc = (idx == `CSR_IDX_IRQC_B0) | (idx == `CSR_IDX_IRQC_B1) |
                        (idx == `CSR_IDX_IRQC_B2) | (idx == `CSR_IDX_IRQC_B3);
  wire       sel_tz   = (idx == `CSR_IDX_TZ_B0) | (idx == `CSR_IDX_TZ_B2);
  wire       sel_evt  = (idx == `CSR_IDX_EVT_STAT);
  wire       sel_mask = (idx == `CSR_IDX_EVT_MASK);

  // ==========================================================
  // Pin synchronisers and edge detection
  wire [5:0] pin_s;        // {port b[3:0], ext irq, timer pin}
  csr_sync2 #(
    .W (6)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({port_b_pins, ext_irq_pin, t0_pin}),
    .q       (pin_s)
  );

  // Keep last synced levels for edge compare
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= 6'h00;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  // Edges stay masked until the compare flop holds a real pin sample;
  // a pin idling high would otherwise fake an edge just after reset
  reg  [1:0] warm_r;                       // Clock cycles since reset, stops at three
  wire       warm_done = (warm_r == 2'h3); // Sync stages and compare flop loaded

  // Saturating warm-up count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_r <= 2'h0;
    end else if (!warm_done) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  wire t0_rise  = warm_done & pin_s[0] & ~pin_prev_r[0];
  wire t0_fall  = warm_done & ~pin_s[0] & pin_prev_r[0];
  wire ext_rise = warm_done & pin_s[1] & ~pin_prev_r[1];
  wire ext_fall = warm_done & ~pin_s[1] & pin_prev_r[1];
  // Edge select 1 counts falling edges of the timer pin
  wire t0_pin_evt = opt_r[`CSR_OP_TZ_EDGE] ? t0_fall : t0_rise;
  // Edge select 1 means interrupt on rising edge
  wire ext_evt    = opt_r[`CSR_OP_EDGE] ? ext_rise : ext_fall;
  // Any change on the upper port b pins
  wire chg_evt    = warm_done & (|(pin_s[5:2] ^ pin_prev_r[5:2]));

  // ==========================================================
  // Prescaler and timer zero
  // Source 1 is the pin, 0 the instruction cycle
  wire tz_tick = opt_r[`CSR_OP_TZ_SRC] ? t0_pin_evt : instr_tick;
  wire tz_inc;             // Prescaled timer increment
  wire wdt_inc_w;          // Prescaled watchdog increment
  // Writes to options, or to the timer while it owns the prescaler, restart
  // the divider, avoiding a stale partial count after the owner or ratio changes
  wire pre_clr = wr & (sel_opt | (sel_tz & ~opt_r[`CSR_OP_ASSIGN]));

  csr_prescaler #(
    .W (8)
  ) u_pre (
    .pclk       (pclk),
    .presetn    (presetn),
    .clr        (pre_clr),
    .assign_wdt (opt_r[`CSR_OP_ASSIGN]),
    .rate       (opt_r[`CSR_OP_RATE_HI:`CSR_OP_RATE_LO]),
    .tmr_tick   (tz_tick),
    .wdt_tick   (wdt_base_tick),
    .tmr_inc    (tz_inc),
    .wdt_inc    (wdt_inc_w)
  );

  // Overflow is the increment that wraps the count back to zero
  wire tz_ovf = tz_inc & (tz_r == 8'hFF);

  // Timer count; a bus write wins over an increment
  always @* begin
    tz_nxt = tz_r;
    if (wr & sel_tz) begin
      tz_nxt = pwdata[7:0];
    end else if (tz_inc) begin
      tz_nxt = tz_r + 8'h01;
    end
  end

  // ==========================================================
  // Adder: subtraction adds the two's complement
  wire [7:0] b_eff = alu_sub ? ~alu_b : alu_b;
  wire [8:0] sum9  = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_sub};
  wire [4:0] lo5   = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub};
  // Zero looks only at the eight result bits, never the carry
  wire       f_z   = (sum9[7:0] == 8'h00);
  wire       f_nib = lo5[4];   // Set means no digit borrow on subtract
  wire       f_c   = sum9[8];  // Set means no borrow on subtract

  // ==========================================================
  // Status register next value
  always @* begin
    stat_nxt = stat_r;
    // Bus write: reset-cause bits are read only
    if (wr & sel_stat) begin
      stat_nxt[7:5] = pwdata[7:5];
      stat_nxt[2:0] = pwdata[2:0];
    end
    // Result of an operation aimed at status
    if (alu_valid & alu_dest_status) begin
      stat_nxt[7:5] = sum9[7:5];
    end
    // Flag results override any write to these three bits
    if (alu_valid) begin
      stat_nxt[`CSR_ST_ZERO]  = f_z;
      stat_nxt[`CSR_ST_NIB]   = f_nib;
      stat_nxt[`CSR_ST_CARRY] = f_c;
    end
    // Reset cause tracking; timeout has the last word
    if (clrwdt_evt) begin
      stat_nxt[`CSR_ST_WDX] = 1'b1;
      stat_nxt[`CSR_ST_SLP] = 1'b1;
    end else if (sleep_evt) begin
      stat_nxt[`CSR_ST_WDX] = 1'b1;
      stat_nxt[`CSR_ST_SLP] = 1'b0;
    end
    if (wdt_timeout_evt) begin
      stat_nxt[`CSR_ST_WDX] = 1'b0;
    end
  end

  // ==========================================================
  // Interrupt control next value
  always @* begin
    irqc_nxt = irqc_r;
    if (wr & sel_irqc) begin
      irqc_nxt = pwdata[7:0];
    end
    // Hardware sets win over a clearing write, no enable consulted
    if (tz_ovf) begin
      irqc_nxt[`CSR_IC_TZ_FLAG] = 1'b1;
    end
    if (ext_evt) begin
      irqc_nxt[`CSR_IC_EXT_FLAG] = 1'b1;
    end
    if (chg_evt) begin
      irqc_nxt[`CSR_IC_CHG_FLAG] = 1'b1;
    end
  end

  // Core request: flags gated by enables, then global enable
  wire core_irq_nxt = irqc_nxt[`CSR_IC_GLOBAL] & (
                      (irqc_nxt[`CSR_IC_TZ_EN]  & irqc_nxt[`CSR_IC_TZ_FLAG])  |
                      (irqc_nxt[`CSR_IC_EXT_EN] & irqc_nxt[`CSR_IC_EXT_FLAG]) |
                      (irqc_nxt[`CSR_IC_CHG_EN] & irqc_nxt[`CSR_IC_CHG_FLAG]) |
                      (irqc_nxt[`CSR_IC_PERIPH] & periph_irq_req));

  // ==========================================================
  // Bus-side sticky events, write one to clear, set wins
  always @* begin
    evt_nxt = evt_r;
    if (wr & sel_evt) begin
      evt_nxt = evt_r & ~pwdata[2:0];
    end
    evt_nxt = evt_nxt | {chg_evt, ext_evt, tz_ovf};
  end

  // ==========================================================
  // Read mux; unmapped indices answer zero with an error
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (sel_stat) begin
      rd_nxt[7:0] = stat_r;
    end else if (sel_opt) begin
      rd_nxt[7:0] = opt_r;
    end else if (sel_irqc) begin
      rd_nxt[7:0] = irqc_r;
    end else if (sel_tz) begin
      rd_nxt[7:0] = tz_r;
    end else if (sel_evt) begin
      rd_nxt[2:0] = evt_r;
    end else if (sel_mask) begin
      rd_nxt[2:0] = mask_r;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // ==========================================================
  // Bus handshake: one wait state so read data come from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      if (psel & penable & ~pready_r) begin
        pready_r  <= 1'b1;
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr_r <= err_nxt;
      end else begin
        // Idle, setup or completion edge: answer drops again
        pready_r  <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r     <= `CSR_RST_STAT;
      opt_r      <= `CSR_RST_OPT;
      irqc_r     <= `CSR_RST_IRQC;
      tz_r       <= `CSR_RST_TZ;
      evt_r      <= `CSR_RST_EVT;
      mask_r     <= `CSR_RST_EVT;
      res_r      <= 8'h00;
      core_irq_r <= 1'b0;
      apb_irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      // Whole byte of options is software writable
      if (wr & sel_opt) begin
        opt_r <= pwdata[7:0];
      end
      if (wr & sel_mask) begin
        mask_r <= pwdata[2:0];
      end
      if (alu_valid) begin
        res_r <= sum9[7:0];
      end
      // Flags, counts and requests follow their next values every cycle
      irqc_r     <= irqc_nxt;
      tz_r       <= tz_nxt;
      evt_r      <= evt_nxt;
      core_irq_r <= core_irq_nxt;
      apb_irq_r  <= |(evt_nxt & mask_r);
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign alu_result = res_r;
  // Bank bits steer direct (two bits) and indirect (one bit) addressing
  assign indirect_bank_select    = stat_r[`CSR_ST_IND_BANK];
  assign direct_bank_select_high = stat_r[`CSR_ST_BANK_HI];
  assign direct_bank_select_low  = stat_r[`CSR_ST_BANK_LO];
  // Pull-up disable goes straight from the option flop to the pads
  assign port_b_pullup_disable   = opt_r[`CSR_OP_PUD];
  assign wdt_inc  = wdt_inc_w;
  assign core_irq = core_irq_r;
  assign apb_irq  = apb_irq_r;

endmodule

//--- tb/csr_core_regs_sva.sv
// Checker of bus timing, bank outputs, arithmetic result and prescaled pulse
module csr_core_regs_sva (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [10:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        alu_valid,
  input logic        alu_sub,
  input logic        alu_dest_status,
  input logic [7:0]  alu_a,
  input logic [7:0]  alu_b,
  input logic [7:0]  alu_result,
  input logic        indirect_bank_select,
  input logic        direct_bank_select_high,
  input logic        direct_bank_select_low,
  input logic        port_b_pullup_disable,
  input logic        wdt_base_tick,
  input logic        wdt_inc
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus phases
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  // Completed write; an arithmetic op in the same cycle would win
  sequence wr_s;
    psel && penable && pready && pwrite && !alu_valid;
  endsequence
  // ==========
  // Bus answers
  ready_wait_a: assert property (acc_s |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  slverr_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without ready");
  // ==========
  // Register effects
  bank_alias_a: assert property (wr_s and paddr[8:2] == 7'h03 |=>
    {indirect_bank_select, direct_bank_select_high, direct_bank_select_low}
    == $past(pwdata[7:5])) else $error("bank bits not written");
  option_alias_a: assert property (wr_s and paddr[9:2] == 8'h81 |=>
    port_b_pullup_disable == $past(pwdata[7])) else $error("pull-up bit not written");
  // ==========
  // Arithmetic
  sub_result_a: assert property (alu_valid && alu_sub |=>
    alu_result == 8'($past(alu_a) - $past(alu_b))) else $error("difference wrong");
  add_result_a: assert property (alu_valid && !alu_sub |=>
    alu_result == 8'($past(alu_a) + $past(alu_b))) else $error("sum wrong");
  alu_bank_a: assert property (alu_valid && alu_dest_status |=>
    {indirect_bank_select, direct_bank_select_high, direct_bank_select_low}
    == alu_result[7:5]) else $error("bank bits not loaded");
  // Prescaled pulse only follows a base tick
  wdt_tick_a: assert property (wdt_inc |-> $past(wdt_base_tick))
    else $error("watchdog pulse without tick");
endmodule
bind csr_core_regs csr_core_regs_sva i_csr_core_regs_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .alu_valid(alu_valid), .alu_sub(alu_sub),
  .alu_dest_status(alu_dest_status), .alu_a(alu_a), .alu_b(alu_b),
  .alu_result(alu_result), .indirect_bank_select(indirect_bank_select),
  .direct_bank_select_high(direct_bank_select_high), .wdt_base_tick(wdt_base_tick),
  .direct_bank_select_low(direct_bank_select_low), .wdt_inc(wdt_inc),
  .port_b_pullup_disable(port_b_pullup_disable));

//--- tb/csr_core_model.sv
// Datapath model: issues one arithmetic op on request, makes watchdog base ticks
module csr_core_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       op_go,
  input  logic       op_sub,
  input  logic       op_dst,
  input  logic [7:0] op_a,
  input  logic [7:0] op_b,
  input  logic       tick_en,
  output logic       alu_valid,
  output logic       alu_sub,
  output logic       alu_dest_status,
  output logic [7:0] alu_a,
  output logic [7:0] alu_b,
  output logic       wdt_base_tick
);
  // ==========
  // One op per request, ticks every other cycle while enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_valid <= 1'b0;
      alu_sub <= 1'b0;
      alu_dest_status <= 1'b0;
      alu_a <= 8'h00;
      alu_b <= 8'h00;
      wdt_base_tick <= 1'b0;
    end else begin
      alu_valid <= op_go;
      alu_sub <= op_sub;
      alu_dest_status <= op_dst;
      // Idle operands keep toggling so stale values are never trusted
      alu_a <= op_go ? op_a : ~alu_a;
      alu_b <= op_go ? op_b : ~alu_b;
      wdt_base_tick <= tick_en && !wdt_base_tick;
    end
  end
endmodule

//--- tb/csr_core_regs_tb_top.sv
// Self-checking bench of the core status/option register block
module csr_core_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [10:0] paddr = 11'h000;
  logic [31:0] pwdata = 32'h0;
  logic        ext_irq_pin = 1'b0, periph_irq_req = 1'b0;
  logic [3:0]  pb = 4'h0;
  logic        wdt_timeout_evt = 1'b0, sleep_evt = 1'b0, clrwdt_evt = 1'b0;
  logic        op_go = 1'b0, op_sub = 1'b0, op_dst = 1'b0, tick_en = 1'b0;
  logic [7:0]  op_a = 8'h00, op_b = 8'h00, st;
  logic [31:0] seed = 32'h00017EF6, rd, v;
  logic [10:0] e;
  logic        err;
  wire  [31:0] prdata;
  wire  [7:0]  alu_a, alu_b, alu_result;
  wire         pready, pslverr, alu_valid, alu_sub, alu_dest_status, wdt_base_tick;
  wire         ind, hi, lo, pud, wdt_inc, core_irq, apb_irq;
  int          n_mismatch = 0, checked = 0, cyc = 0, n_inc = 0, i, j;
  always #2 pclk = ~pclk;
  csr_core_regs i_csr_core_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_tick(wdt_base_tick),
    .wdt_base_tick(wdt_base_tick),
    .t0_pin(1'b0), .ext_irq_pin(ext_irq_pin), .port_b_pins(pb),
    .periph_irq_req(periph_irq_req), .alu_valid(alu_valid), .alu_sub(alu_sub),
    .alu_dest_status(alu_dest_status), .alu_a(alu_a), .alu_b(alu_b),
    .wdt_timeout_evt(wdt_timeout_evt), .sleep_evt(sleep_evt), .clrwdt_evt(clrwdt_evt),
    .alu_result(alu_result), .indirect_bank_select(ind), .direct_bank_select_high(hi),
    .direct_bank_select_low(lo), .port_b_pullup_disable(pud), .wdt_inc(wdt_inc),
    .core_irq(core_irq), .apb_irq(apb_irq));
  csr_core_model i_csr_core_model (.pclk(pclk), .presetn(presetn), .op_go(op_go),
    .op_sub(op_sub), .op_dst(op_dst), .op_a(op_a), .op_b(op_b), .tick_en(tick_en),
    .alu_valid(alu_valid), .alu_sub(alu_sub), .alu_dest_status(alu_dest_status),
    .alu_a(alu_a), .alu_b(alu_b), .wdt_base_tick(wdt_base_tick));
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Result, zero, nibble and carry; borrow shows as a cleared carry
  function automatic logic [10:0] alu_exp(input logic s, input logic [7:0] a, b);
    logic [8:0] r;
    logic [4:0] n;
    r = s ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
    n = s ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01 : {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {r[7:0], r[7:0] == 8'h00, n[4], r[8]};
  endfunction
  // Full transfer; request held until ready is sampled
  task apb(input logic w, input logic [10:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task rdchk(input logic [10:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask
  task end_of_test();
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Prescaled pulse counter and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (wdt_inc === 1'b1) n_inc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ==========
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(11'h00C, 32'h18);
    rdchk(11'h204, 32'hFF);
    // Write at each alias, read back at all four
    for (i = 0; i < 4; i++) begin
      v = rnd();
      st = {v[7:5], 2'b11, v[2:0]};
      apb(1'b1, 11'h00C | 11'(i << 9), v);
      for (j = 0; j < 4; j++) rdchk(11'h00C | 11'(j << 9), {24'h0, st});
    end
    chk_reg({ind, hi, lo}, st[7:5]);
    for (i = 0; i < 2; i++) begin
      v = rnd();
      apb(1'b1, i ? 11'h604 : 11'h204, v);
      rdchk(i ? 11'h204 : 11'h604, {24'h0, v[7:0]});
      chk_bit(pud, v[7]);
    end
    apb(1'b1, 11'h204, 32'hFF);
    // Borrow, nibble carry and zero corners, then random ops
    for (i = 0; i < 14; i++) begin
      v = (i == 0) ? 32'h00010001 : (i == 1) ? 32'h00010F00 : (i == 2) ? 32'h00555501 : rnd();
      op_sub <= v[0];
      op_dst <= v[1];
      op_a <= v[15:8];
      op_b <= v[23:16];
      op_go <= 1'b1;
      @(posedge pclk);
      op_go <= 1'b0;
      repeat (3) @(posedge pclk);
      e = alu_exp(v[0], v[15:8], v[23:16]);
      chk_reg(alu_result, e[10:3]);
      if (v[1]) st[7:5] = e[10:8];
      st[2:0] = e[2:0];
      rdchk(11'h00C, {24'h0, st});
    end
    // Sleep, timeout, clear-watchdog effects on the reset-cause bits
    for (i = 0; i < 3; i++) begin
      sleep_evt <= (i == 0);
      wdt_timeout_evt <= (i == 1);
      clrwdt_evt <= (i == 2);
      @(posedge pclk);
      {sleep_evt, wdt_timeout_evt, clrwdt_evt} <= 3'b000;
      st[4:3] = (i == 0) ? 2'b10 : (i == 1) ? 2'b00 : 2'b11;
      rdchk(11'h00C, {24'h0, st});
    end
    // Flag sets with every enable off, then enable gating of the core request
    ext_irq_pin <= 1'b1;
    pb <= 4'h5;
    repeat (6) @(posedge pclk);
    rdchk(11'h02C, 32'h03);
    chk_bit(core_irq, 1'b0);
    rdchk(11'h7C0, 32'h6);
    apb(1'b1, 11'h7C4, 32'h2);
    repeat (2) @(posedge pclk);
    chk_bit(apb_irq, 1'b1);
    apb(1'b1, 11'h7C0, 32'h2);
    repeat (2) @(posedge pclk);
    chk_bit(apb_irq, 1'b0);
    apb(1'b1, 11'h22C, 32'h0);
    apb(1'b1, 11'h42C, 32'h90);
    repeat (3) @(posedge pclk);
    chk_bit(core_irq, 1'b0);
    ext_irq_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_irq_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk_bit(core_irq, 1'b1);
    rdchk(11'h62C, 32'h92);
    apb(1'b1, 11'h02C, 32'h80);
    periph_irq_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_bit(core_irq, 1'b0);
    apb(1'b1, 11'h02C, 32'hC0);
    repeat (3) @(posedge pclk);
    chk_bit(core_irq, 1'b1);
    periph_irq_req <= 1'b0;
    // Every watchdog rate with timer at 1:1, then timer ownership
    for (i = 0; i < 9; i++) begin
      apb(1'b1, 11'h204, (i < 8) ? 32'hD8 | i : 32'hD6);
      apb(1'b1, 11'h404, 32'h0);
      n_inc = 0;
      tick_en <= 1'b1;
      repeat (256) @(posedge pclk);
      tick_en <= 1'b0;
      repeat (4) @(posedge pclk);
      chk_reg(n_inc, (i < 8) ? 128 >> i : 128);
      rdchk(11'h004, (i < 8) ? 32'h80 : 32'h01);
    end
    // Unmapped place refuses and reads zero
    apb(1'b1, 11'h010, 32'hFF);
    apb(1'b0, 11'h010, 32'h0);
    chk_reg(rd, 32'h0);
    chk_bit(err, 1'b1);
    end_of_test();
  end
endmodule
